/* File: core/adc_serial_register_port.v */
// Serial register port of a sigma-delta converter: command decode, register transfers,
// status word, continuous read and framing recovery.
// Assumes a host drives i_sclk and i_din; the conversion datapath runs on i_mclk.
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module adc_serial_register_port (
    input wire i_mclk,
    input wire i_rst,
    input wire i_sclk,
    input wire i_din,
    input wire i_sync_n,
    input wire i_result_valid,
    input wire [23:0] i_result,
    input wire i_result_clamped,
    input wire i_ref_low,
    input wire [2:0] i_channel,
    input wire i_pre_update,
    input wire i_halted,
    output reg o_dout,
    output reg [23:0] o_mode,
    output reg [23:0] o_config,
    output reg [7:0] o_gpo,
    output reg [23:0] o_zero_cal,
    output reg [23:0] o_gain_cal,
    output reg o_filter_restart,
    output reg o_part_reset,
    output reg o_continuous_read,
    output wire [7:0] o_status
);
    localparam [1:0] ST_WAIT = 2'h0;
    localparam [1:0] ST_WRITE = 2'h1;
    localparam [1:0] ST_READ = 2'h2;
    localparam [1:0] ST_CONT = 2'h3;
    localparam [7:0] STATUS_INIT = `STATUS_RESET;

    wire [2:0] pin_level;
    wire [2:0] pin_rise;
    wire [2:0] pin_fall;
    wire din;
    wire sclk_rise;
    wire sclk_fall;
    wire sync_low;
    wire rst_all;

    reg [1:0] state;
    reg [5:0] bit_cnt;
    reg [5:0] xfer_len;
    reg [2:0] xfer_sel;
    reg [5:0] cmd_bits;
    reg [22:0] in_shift;
    reg [31:0] out_shift;
    reg [7:0] exit_window;
    reg [5:0] ones_cnt;
    reg [23:0] result;
    reg rdy_n;
    reg err;
    reg missing_reference_flag;
    reg parity;
    reg [2:0] chan;
    reg read_done;
    reg mode_write;

    wire [6:0] cmd_full;
    wire [2:0] cmd_sel;
    wire [23:0] write_value;
    wire [23:0] stored_result;

    pin_sync u_pin_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pins({i_sync_n, i_din, i_sclk}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    assign din = pin_level[1];
    assign sclk_rise = pin_rise[0];
    assign sclk_fall = pin_fall[0];
    assign sync_low = ~pin_level[2];
    assign rst_all = i_rst | o_part_reset;
    assign cmd_full = {cmd_bits, din};
    assign cmd_sel = cmd_full[`CMD_SEL_HI:`CMD_SEL_LO];
    assign write_value = {in_shift, din};
    assign o_status = {rdy_n, err, missing_reference_flag, parity, 1'b0, chan};
    assign stored_result = (o_config[`CFG_REF_DETECT_BIT] & i_ref_low) ?
        24'hffffff : i_result;

    // Length of the data phase for a register select.
    function [5:0] sel_len;
        input [2:0] sel;
        input append;
        begin
            if (sel == `ADDR_RESULT) begin
                sel_len = append ? `LEN_RESULT_STATUS : `LEN_WORD;
            end else if (sel == `ADDR_COMMAND_STATUS || sel == `ADDR_IDENTITY ||
                         sel == `ADDR_GPO) begin
                sel_len = `LEN_BYTE;
            end else begin
                sel_len = `LEN_WORD;
            end
        end
    endfunction

    // Read value, left aligned so the first bit out is bit 31.
    function [31:0] read_value;
        input [2:0] sel;
        input [7:0] status;
        input [23:0] mode;
        input [23:0] cfg;
        input [23:0] res;
        input [7:0] gpo;
        input [23:0] zcal;
        input [23:0] gcal;
        begin
            if (sel == `ADDR_COMMAND_STATUS) begin
                read_value = {status, 24'h000000};
            end else if (sel == `ADDR_MODE) begin
                read_value = {mode, 8'h00};
            end else if (sel == `ADDR_CONFIG) begin
                read_value = {cfg, 8'h00};
            end else if (sel == `ADDR_RESULT) begin
                read_value = {res, status};
            end else if (sel == `ADDR_IDENTITY) begin
                read_value = {`IDENTITY_VALUE, 24'h000000};
            end else if (sel == `ADDR_GPO) begin
                read_value = {gpo, 24'h000000};
            end else if (sel == `ADDR_ZERO_CAL) begin
                read_value = {zcal, 8'h00};
            end else begin
                read_value = {gcal, 8'h00};
            end
        end
    endfunction

    // Consecutive high bits on rising serial clock edges reset the whole part.
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ones_cnt <= 6'h00;
            o_part_reset <= 1'b0;
        end else begin
            o_part_reset <= 1'b0;
            if (sclk_rise) begin
                if (!din) begin
                    ones_cnt <= 6'h00;
                end else if (ones_cnt == `ONES_RESET_COUNT - 6'h01) begin
                    ones_cnt <= 6'h00;
                    o_part_reset <= 1'b1;
                end else begin
                    ones_cnt <= ones_cnt + 6'h01;
                end
            end
        end
    end

    // Command decode and transfer sequencing.
    always @(posedge i_mclk) begin
        if (rst_all) begin
            state <= ST_WAIT;
            bit_cnt <= 6'h00;
            xfer_len <= `LEN_BYTE;
            xfer_sel <= `ADDR_COMMAND_STATUS;
            cmd_bits <= 6'h00;
            in_shift <= 23'h000000;
            out_shift <= 32'h00000000;
            exit_window <= 8'hff;
            o_continuous_read <= 1'b0;
            o_dout <= 1'b1;
            o_mode <= `MODE_RESET;
            o_config <= `CONFIG_RESET;
            o_gpo <= `GPO_RESET;
            o_zero_cal <= `ZERO_CAL_RESET;
            o_gain_cal <= `GAIN_CAL_RESET;
            o_filter_restart <= 1'b0;
            read_done <= 1'b0;
            mode_write <= 1'b0;
        end else begin
            o_filter_restart <= 1'b0;
            read_done <= 1'b0;
            mode_write <= 1'b0;
            if (state != ST_READ) begin
                o_dout <= rdy_n;
            end
            if (o_continuous_read && sclk_rise) begin
                exit_window <= {exit_window[6:0], din};
            end
            case (state)
                ST_WAIT: begin
                    if (sclk_rise) begin
                        if (bit_cnt == 6'h00) begin
                            if (!din) begin
                                bit_cnt <= 6'h01;
                            end
                        end else if (bit_cnt != 6'h07) begin
                            cmd_bits <= {cmd_bits[4:0], din};
                            bit_cnt <= bit_cnt + 6'h01;
                        end else begin
                            bit_cnt <= 6'h00;
                            xfer_sel <= cmd_sel;
                            xfer_len <= sel_len(cmd_sel, o_mode[`MODE_APPEND_STATUS_BIT]);
                            if (cmd_full[`CMD_DIR_BIT]) begin
                                if (cmd_sel == `ADDR_RESULT && cmd_full[`CMD_CONT_BIT]) begin
                                    o_continuous_read <= 1'b1;
                                    exit_window <= 8'hff;
                                    state <= ST_CONT;
                                end else begin
                                    out_shift <= read_value(cmd_sel, o_status, o_mode,
                                        o_config, result, o_gpo, o_zero_cal,
                                        o_gain_cal);
                                    state <= ST_READ;
                                end
                            end else if (cmd_sel != `ADDR_COMMAND_STATUS) begin
                                state <= ST_WRITE;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    if (sclk_rise) begin
                        in_shift <= {in_shift[21:0], din};
                        if (bit_cnt == xfer_len - 6'h01) begin
                            bit_cnt <= 6'h00;
                            state <= ST_WAIT;
                            if (xfer_sel == `ADDR_MODE) begin
                                o_mode <= write_value;
                                o_filter_restart <= 1'b1;
                                mode_write <= 1'b1;
                            end else if (xfer_sel == `ADDR_CONFIG) begin
                                o_config <= write_value;
                            end else if (xfer_sel == `ADDR_GPO) begin
                                o_gpo <= write_value[7:0];
                            end else if (xfer_sel == `ADDR_ZERO_CAL) begin
                                o_zero_cal <= write_value;
                            end else if (xfer_sel == `ADDR_GAIN_CAL) begin
                                o_gain_cal <= write_value;
                            end
                        end else begin
                            bit_cnt <= bit_cnt + 6'h01;
                        end
                    end
                end
                ST_READ: begin
                    if (sclk_fall) begin
                        o_dout <= out_shift[31];
                        out_shift <= {out_shift[30:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        if (o_continuous_read &&
                            {exit_window[6:0], din} == `CMD_EXIT_CONT) begin
                            o_continuous_read <= 1'b0;
                            bit_cnt <= 6'h00;
                            state <= ST_WAIT;
                        end else if (bit_cnt == xfer_len - 6'h01) begin
                            bit_cnt <= 6'h00;
                            read_done <= (xfer_sel == `ADDR_RESULT);
                            state <= o_continuous_read ? ST_CONT : ST_WAIT;
                        end else begin
                            bit_cnt <= bit_cnt + 6'h01;
                        end
                    end
                end
                default: begin
                    if (sclk_rise && {exit_window[6:0], din} == `CMD_EXIT_CONT) begin
                        o_continuous_read <= 1'b0;
                        state <= ST_WAIT;
                    end else if (!rdy_n && !read_done) begin
                        xfer_len <= sel_len(`ADDR_RESULT, o_mode[`MODE_APPEND_STATUS_BIT]);
                        xfer_sel <= `ADDR_RESULT;
                        out_shift <= {result, o_status};
                        bit_cnt <= 6'h00;
                        state <= ST_READ;
                    end
                end
            endcase
        end
    end

    // Status word: a new result clears ready unless sync, halt, a mode write or pre-update sets it in the same cycle; a result read sets it again.
    always @(posedge i_mclk) begin
        if (rst_all) begin
            rdy_n <= STATUS_INIT[7];
            err <= 1'b0;
            missing_reference_flag <= 1'b0;
            parity <= 1'b0;
            chan <= 3'h0;
            result <= 24'h000000;
        end else begin
            if (i_result_valid) begin
                result <= stored_result;
                err <= i_result_clamped |
                    (o_config[`CFG_REF_DETECT_BIT] & i_ref_low);
                missing_reference_flag <= o_config[`CFG_REF_DETECT_BIT] & i_ref_low;
                parity <= o_mode[`MODE_PARITY_ENABLE_BIT] & (^stored_result);
                chan <= i_channel;
            end
            if (sync_low || i_halted || mode_write || i_pre_update) begin
                rdy_n <= 1'b1;
            end else if (i_result_valid) begin
                rdy_n <= 1'b0;
            end else if (read_done) begin
                rdy_n <= 1'b1;
            end
        end
    end
endmodule // adc_serial_register_port

/* File: core/adc_port_defines.vh */
// Constants for the converter serial register port.
// Assumes inclusion by the port core and its bench only.
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH

// Register select codes.
`define ADDR_COMMAND_STATUS 3'h0
`define ADDR_MODE 3'h1
`define ADDR_CONFIG 3'h2
`define ADDR_RESULT 3'h3
`define ADDR_IDENTITY 3'h4
`define ADDR_GPO 3'h5
`define ADDR_ZERO_CAL 3'h6
`define ADDR_GAIN_CAL 3'h7

// Command byte fields, counted on the seven bits after the enable bit.
`define CMD_DIR_BIT 6
`define CMD_SEL_HI 5
`define CMD_SEL_LO 3
`define CMD_CONT_BIT 2
`define CMD_EXIT_CONT 8'h58

// Transfer lengths in bits.
`define LEN_BYTE 6'h08
`define LEN_WORD 6'h18
`define LEN_RESULT_STATUS 6'h20

// Mode and configuration field positions.
`define MODE_APPEND_STATUS_BIT 20
`define MODE_PARITY_ENABLE_BIT 13
`define CFG_REF_DETECT_BIT 20

// Reset values.
`define STATUS_RESET 8'h80
`define MODE_RESET 24'h080060
`define CONFIG_RESET 24'h000000
`define GPO_RESET 8'h00
`define ZERO_CAL_RESET 24'h800000
`define GAIN_CAL_RESET 24'h500000
// Identity value is arbitrary.
`define IDENTITY_VALUE 8'h5a

// Framing recovery: consecutive high input bits that reset the part.
`define ONES_RESET_COUNT 6'h28

`endif

/* File: core/pin_sync.v */
// Two-stage synchroniser with edge detection for a group of pin inputs.
// Assumes pins are asynchronous to i_mclk and change slower than it.
`timescale 1ns/1ps
module pin_sync (
    input wire i_mclk,
    input wire i_rst,
    input wire [2:0] i_pins,
    output wire [2:0] o_level,
    output wire [2:0] o_rise,
    output wire [2:0] o_fall
);
    reg [2:0] stage_a;
    reg [2:0] stage_b;
    reg [2:0] stage_c;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_bit
            // The first stage feeds only the second stage.
            always @(posedge i_mclk) begin
                if (i_rst) begin
                    stage_a[g] <= 1'b1;
                    stage_b[g] <= 1'b1;
                    stage_c[g] <= 1'b1;
                end else begin
                    stage_a[g] <= i_pins[g];
                    stage_b[g] <= stage_a[g];
                    stage_c[g] <= stage_b[g];
                end
            end
            assign o_level[g] = stage_b[g];
            assign o_rise[g] = stage_b[g] & ~stage_c[g];
            assign o_fall[g] = ~stage_b[g] & stage_c[g];
        end
    endgenerate
endmodule // pin_sync

/* File: tb/adc_port_sva.sv */
// Concurrent checks on the converter serial register port, bound to its top module.
// Assumes the datapath inputs share i_mclk and i_rst is synchronous, active high.
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module adc_port_sva (
    input wire i_mclk,
    input wire i_rst,
    input wire i_sync_n,
    input wire i_result_valid,
    input wire [23:0] i_result,
    input wire i_result_clamped,
    input wire i_ref_low,
    input wire [2:0] i_channel,
    input wire i_pre_update,
    input wire i_halted,
    input wire [23:0] o_mode,
    input wire o_filter_restart,
    input wire o_part_reset,
    input wire o_continuous_read,
    input wire [7:0] o_status
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    reset_values_a: assert property ($fell(i_rst) |->
        o_status == `STATUS_RESET && o_mode == `MODE_RESET) else $error("Bad reset values.");
    part_reset_a: assert property (o_part_reset |-> ##2 (o_mode == `MODE_RESET &&
        !o_continuous_read && o_status == `STATUS_RESET)) else $error("Part reset missed.");
    filter_ready_a: assert property (o_filter_restart |-> ##[1:2] o_status[7])
        else $error("Mode write left ready low.");
    result_ready_a: assert property (i_result_valid && $past(i_sync_n, 2) && !i_halted &&
        !i_pre_update && !o_part_reset && !o_filter_restart |=> !o_status[7])
        else $error("Ready not cleared.");
    error_flag_a: assert property (i_result_valid && i_result_clamped |=> o_status[6])
        else $error("Error flag not set.");
    channel_tag_a: assert property (i_result_valid |=> o_status[2:0] == $past(i_channel))
        else $error("Channel tag wrong.");
    parity_off_a: assert property (i_result_valid && !o_mode[13] |=> !o_status[4])
        else $error("Parity kept while disabled.");
    parity_on_a: assert property (i_result_valid && o_mode[13] && !i_ref_low |=>
        o_status[4] == ^$past(i_result)) else $error("Parity bit wrong.");
    early_ready_a: assert property (i_pre_update |=> o_status[7])
        else $error("Pre-update left ready low.");
    halt_ready_a: assert property (i_halted |=> o_status[7])
        else $error("Halt left ready low.");
endmodule // adc_port_sva
bind adc_serial_register_port adc_port_sva i_sva (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sync_n(i_sync_n), .i_result_valid(i_result_valid), .i_result(i_result),
    .i_result_clamped(i_result_clamped), .i_ref_low(i_ref_low), .i_channel(i_channel),
    .i_pre_update(i_pre_update), .i_halted(i_halted), .o_mode(o_mode),
    .o_filter_restart(o_filter_restart), .o_part_reset(o_part_reset),
    .o_continuous_read(o_continuous_read), .o_status(o_status));

/* File: tb/host_port_model.sv */
// Host controller model that clocks the serial port and captures the data-out pin.
// Assumes i_mclk runs at 10 MHz; one serial bit takes 8 cycles, 800 ns.
`timescale 1ns/1ps
module host_port_model (
    input wire i_mclk,
    input wire i_dout,
    output logic o_sclk,
    output logic o_din
);
    initial begin
        o_sclk = 1'b1;
        o_din = 1'b0;
    end
    // Shifts n bits out and captures the data-out pin before each rising serial clock.
    task automatic shift(input logic [39:0] tx, input int n, output logic [39:0] rx);
        rx = 40'h0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_mclk);
            o_sclk <= 1'b0;
            o_din <= tx[i];
            repeat (4) @(posedge i_mclk);
            @(negedge i_mclk);
            rx[i] = i_dout;
            @(posedge i_mclk);
            o_sclk <= 1'b1;
            repeat (2) @(posedge i_mclk);
        end
        @(posedge i_mclk);
        o_din <= 1'b0;
    endtask
endmodule // host_port_model

/* File: tb/adc_serial_register_port_tb_top.sv */
// Self-checking bench for the converter serial register port.
// Assumes the host model drives the serial pins and the bench drives the datapath side.
`timescale 1ns/1ps
`include "adc_port_defines.vh"
module adc_serial_register_port_tb_top;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_sync_n = 1'b1, i_result_valid = 1'b0;
    logic i_result_clamped = 1'b0, i_ref_low = 1'b0, i_pre_update = 1'b0, i_halted = 1'b0;
    logic [23:0] i_result = 24'h0;
    logic [2:0] i_channel = 3'h0;
    logic sclk, din, o_dout, o_filter_restart, o_part_reset, o_continuous_read;
    logic [23:0] o_mode, o_config, o_zero_cal, o_gain_cal;
    logic [7:0] o_gpo, o_status;
    logic [39:0] v;
    int failures = 0, n_checks = 0;
    int addr[5] = '{1, 2, 5, 6, 7};
    int width[5] = '{24, 24, 8, 24, 24};
    logic [23:0] val[5] = '{24'h182060, 24'h00a5c3, 24'h00003c, 24'h123456, 24'h654321};
    always #50 i_mclk = ~i_mclk;
    host_port_model i_host (.i_mclk(i_mclk), .i_dout(o_dout), .o_sclk(sclk), .o_din(din));
    adc_serial_register_port i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk),
        .i_din(din), .i_sync_n(i_sync_n), .i_result_valid(i_result_valid),
        .i_result(i_result), .i_result_clamped(i_result_clamped), .i_ref_low(i_ref_low),
        .i_channel(i_channel), .i_pre_update(i_pre_update), .i_halted(i_halted),
        .o_dout(o_dout), .o_mode(o_mode), .o_config(o_config), .o_gpo(o_gpo),
        .o_zero_cal(o_zero_cal), .o_gain_cal(o_gain_cal), .o_filter_restart(o_filter_restart),
        .o_part_reset(o_part_reset), .o_continuous_read(o_continuous_read),
        .o_status(o_status));
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("Checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Sends a command byte, then a data phase of n bits.
    task automatic xfer(input logic [7:0] cmd, input logic [39:0] tx, input int n);
        i_host.shift({32'h0, cmd}, 8, v);
        i_host.shift(tx, n, v);
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    // Hands one result to the port as the datapath would.
    task automatic put_result(input logic [23:0] r, input logic [2:0] ch, input logic cl);
        @(posedge i_mclk);
        i_result <= r;
        i_channel <= ch;
        i_result_clamped <= cl;
        i_result_valid <= 1'b1;
        @(posedge i_mclk);
        i_result_valid <= 1'b0;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    function automatic logic [23:0] reg_out(input int a);
        case (a)
            1: return o_mode;
            2: return o_config;
            5: return {16'h0, o_gpo};
            6: return o_zero_cal;
            default: return o_gain_cal;
        endcase
    endfunction
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_mclk);
        @(negedge i_mclk);
        check("status", o_status, `STATUS_RESET);
        check("mode", o_mode, `MODE_RESET);
        check("dout", o_dout, 1'b1);
        check("cont", o_continuous_read, 1'b0);
        $display("Test reset done");
        i_host.shift(40'h740, 11, v);
        i_host.shift(40'h0, 8, v);
        check("status read", v, 40'h80);
        for (int k = 0; k < 5; k++) begin
            xfer({2'b00, addr[k][2:0], 3'b000}, {16'h0, val[k]}, width[k]);
            check("reg write", reg_out(addr[k]), val[k]);
            xfer({2'b01, addr[k][2:0], 3'b000}, 40'h0, width[k]);
            check("reg read", v, {16'h0, val[k]});
        end
        $display("Test registers done");
        put_result(24'h000007, 3'h5, 1'b0);
        check("status", o_status, 8'h15);
        check("dout ready", o_dout, 1'b0);
        xfer(8'h58, 40'h0, 32);
        check("result read", v, 40'h0000000715);
        check("ready set", o_status[7], 1'b1);
        xfer(8'h60, 40'h0, 8);
        check("identity", v, {32'h0, `IDENTITY_VALUE});
        $display("Test result done");
        put_result(24'hffffff, 3'h1, 1'b1);
        check("error", o_status[7:6], 2'b01);
        @(posedge i_mclk) i_pre_update <= 1'b1;
        @(posedge i_mclk) i_pre_update <= 1'b0;
        @(negedge i_mclk) check("pre update", o_status[7], 1'b1);
        put_result(24'h000003, 3'h2, 1'b0);
        check("error clear", o_status[7:6], 2'b00);
        @(posedge i_mclk) i_sync_n <= 1'b0;
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk) check("sync", o_status[7], 1'b1);
        @(posedge i_mclk) i_sync_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        put_result(24'h000001, 3'h3, 1'b0);
        check("ready low", o_status[7], 1'b0);
        @(posedge i_mclk) i_halted <= 1'b1;
        @(posedge i_mclk) i_halted <= 1'b0;
        @(negedge i_mclk) check("halt", o_status[7], 1'b1);
        xfer(8'h10, 40'h100000, 24);
        check("config", o_config, 24'h100000);
        @(posedge i_mclk) i_ref_low <= 1'b1;
        put_result(24'h000001, 3'h3, 1'b0);
        check("no reference", o_status[6:5], 2'b11);
        @(posedge i_mclk) i_ref_low <= 1'b0;
        xfer(8'h58, 40'h0, 32);
        check("clamped read", v, 40'h00ffffff63);
        repeat (6) @(posedge i_mclk);
        $display("Test status done");
        i_host.shift(40'h5c, 8, v);
        repeat (4) @(negedge i_mclk);
        check("cont on", o_continuous_read, 1'b1);
        put_result(24'h800001, 3'h2, 1'b0);
        i_host.shift(40'h0, 32, v);
        check("cont read", v, 40'h0080000102);
        i_host.shift(40'h58, 8, v);
        repeat (4) @(negedge i_mclk);
        check("cont off", o_continuous_read, 1'b0);
        $display("Test continuous done");
        i_host.shift(40'hffffffffff, 40, v);
        repeat (4) @(negedge i_mclk);
        check("mode after ones", o_mode, `MODE_RESET);
        xfer(8'h40, 40'h0, 8);
        check("status after ones", v, 40'h80);
        $display("Test recovery done");
        conclude();
    end
    initial begin
        repeat (90000) @(posedge i_mclk);
        failures++;
        conclude();
    end
endmodule // adc_serial_register_port_tb_top
